// [logic/sdc_pkg.sv]
// Constants, register map and encodings of the converter sync and output port.
// Assumes one 10 MHz fabric clock; the master clock is an internal tick derived from it.

package sdc_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_RESULT = 8'h08;

    // Control fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int MODE_W = 2;
    localparam int CTRL_PAR_BIT = 2;
    localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0001;

    // Status fields
    localparam int STAT_RUN_BIT = 0;
    localparam int STAT_SETTLE_BIT = 1;
    localparam int STAT_LOCK_BIT = 2;
    localparam int STAT_PAR_BIT = 3;
    localparam int STAT_MODE_LSB = 4;
    localparam int STAT_SEQ_LSB = 8;

    // ************************************************************
    // Serial mode encodings
    // ************************************************************
    localparam logic [MODE_W-1:0] MODE_1 = 2'h1;
    localparam logic [MODE_W-1:0] MODE_2 = 2'h2;
    localparam logic [MODE_W-1:0] MODE_3 = 2'h3;

    // ************************************************************
    // Word and timing figures
    // ************************************************************
    localparam int WORD_W = 16;
    localparam int FRAME_LONG = 32;
    localparam int CLK_PER_MCLK = 2;
    localparam int DECIM_LONG = 32;
    localparam int DECIM_SHORT = 16;
    localparam int DATA_READY_N_HIGH_MCLK = 2;
    localparam int CNT_W = 6;
    localparam int SEQ_W = CNT_W - 1;
    localparam logic [CNT_W-1:0] CNT_LAST_LONG = CNT_W'(DECIM_LONG * CLK_PER_MCLK - 1);
    localparam logic [CNT_W-1:0] CNT_LAST_SHORT = CNT_W'(DECIM_SHORT * CLK_PER_MCLK - 1);
    localparam logic [CNT_W-1:0] DATA_READY_N_CLK = CNT_W'(DATA_READY_N_HIGH_MCLK * CLK_PER_MCLK);

    typedef enum logic [1:0] {
        SDC_FLT_RESET,
        SDC_FLT_SETTLE,
        SDC_FLT_RUN
    } sdc_flt_e;

endpackage

// [logic/sdc_port.sv]
// Converter filter sequencer, sync handling, parallel port and serial master port.
// Assumes the filter result arrives on result_in in the clk_in domain; all pins are
// asynchronous and pass two flip-flops; registers are reached over APB.
`timescale 1ns/10ps

module sdc_port #(
    parameter int SETTLE_WORDS = 8
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [sdc_pkg::ADDR_W-1:0] paddr_in,
    input wire logic [sdc_pkg::DATA_W-1:0] pwdata_in,
    output logic [sdc_pkg::DATA_W-1:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Filter side
    input wire logic [sdc_pkg::WORD_W-1:0] result_in,
    output logic filter_reset_out,
    output logic [sdc_pkg::SEQ_W-1:0] seq_count_out,
    // Sync and format pins
    input wire logic filter_sync_in,
    input wire logic frame_sync_in,
    input wire logic clock_edge_select_in,
    input wire logic frame_format_select_in,
    input wire logic slot_select_in,
    input wire logic output_enable_in,
    // Parallel port
    input wire logic chip_select_n_in,
    input wire logic read_n_in,
    output logic data_ready_n_out,
    output logic [sdc_pkg::WORD_W-1:0] parallel_data_out,
    output logic parallel_data_oe_n_out,
    // Serial port
    output logic serial_clock_out,
    output logic serial_data_out,
    output logic serial_data_oe_n_out,
    output logic frame_sync_out
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    localparam int NPIN = 8;
    logic [NPIN-1:0] pin_meta;
    logic [NPIN-1:0] pin_sync;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= {filter_sync_in, frame_sync_in, clock_edge_select_in,
                         frame_format_select_in, slot_select_in, output_enable_in,
                         chip_select_n_in, read_n_in};
            pin_sync <= pin_meta;
        end
    end

    logic sync_s;
    logic fsi_s;
    logic ces_s;
    logic frame_format_select_s;
    logic slot_s;
    logic oe_s;
    logic cs_n_s;
    logic rd_n_s;

    assign {sync_s, fsi_s, ces_s, frame_format_select_s, slot_s, oe_s, cs_n_s, rd_n_s} = pin_sync;

    // Edge history of the two sync pins
    logic sync_d;
    logic fsi_d;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync_d <= 1'b0;
            fsi_d <= 1'b0;
        end else begin
            sync_d <= sync_s;
            fsi_d <= fsi_s;
        end
    end

    logic sync_rise;
    logic fsi_rise;

    assign sync_rise = sync_s && !sync_d;
    assign fsi_rise = fsi_s && !fsi_d;

    // ************************************************************
    // Control register
    // ************************************************************
    logic [sdc_pkg::DATA_W-1:0] ctrl;
    logic apb_access;
    logic apb_setup;
    logic addr_ok;

    assign apb_access = psel_in && penable_in;
    assign apb_setup = psel_in && !penable_in;
    assign addr_ok = (paddr_in == sdc_pkg::REG_CTRL) || (paddr_in == sdc_pkg::REG_STATUS) ||
                     (paddr_in == sdc_pkg::REG_RESULT);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl <= sdc_pkg::CTRL_RESET;
        end else if (apb_access && pwrite_in && paddr_in == sdc_pkg::REG_CTRL) begin
            ctrl <= pwdata_in;
        end
    end

    // ************************************************************
    // Active configuration, taken only at sync points
    // ************************************************************
    sdc_pkg::sdc_flt_e state;
    logic [sdc_pkg::MODE_W-1:0] act_mode;
    logic act_par;
    logic fsi_locked;
    logic fsi_take;

    // Frame sync in counts only when not a mode 1 pulse format
    assign fsi_take = fsi_rise && !fsi_locked &&
                      (act_mode != sdc_pkg::MODE_1 || frame_format_select_s);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            act_mode <= sdc_pkg::CTRL_RESET[sdc_pkg::CTRL_MODE_LSB +: sdc_pkg::MODE_W];
            act_par <= sdc_pkg::CTRL_RESET[sdc_pkg::CTRL_PAR_BIT];
        end else if (state == sdc_pkg::SDC_FLT_RESET || fsi_take) begin
            act_mode <= ctrl[sdc_pkg::CTRL_MODE_LSB +: sdc_pkg::MODE_W];
            act_par <= ctrl[sdc_pkg::CTRL_PAR_BIT];
        end
    end

    // ************************************************************
    // Filter sequencer and settle tracking
    // ************************************************************
    logic [sdc_pkg::CNT_W-1:0] cnt;
    logic [sdc_pkg::CNT_W-1:0] cnt_last;
    logic mclk_ph;
    logic word_end;
    logic [7:0] settle_cnt;
    logic settle_last;

    always_comb begin
        unique case (act_mode)
            sdc_pkg::MODE_3: cnt_last = sdc_pkg::CNT_LAST_SHORT;
            default: cnt_last = sdc_pkg::CNT_LAST_LONG;
        endcase
    end

    assign word_end = (state != sdc_pkg::SDC_FLT_RESET) && (cnt == cnt_last);
    assign settle_last = (settle_cnt == 8'(SETTLE_WORDS - 1));

    // Free-running master clock phase, low on master rising edges
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mclk_ph <= 1'b0;
        end else begin
            mclk_ph <= !mclk_ph;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= sdc_pkg::SDC_FLT_SETTLE;
        end else if (sync_rise) begin
            state <= sdc_pkg::SDC_FLT_RESET;
        end else if (fsi_take) begin
            state <= sdc_pkg::SDC_FLT_SETTLE;
        end else begin
            unique case (state)
                sdc_pkg::SDC_FLT_RESET: begin
                    if (!sync_s && !mclk_ph) begin
                        state <= sdc_pkg::SDC_FLT_SETTLE;
                    end
                end
                sdc_pkg::SDC_FLT_SETTLE: begin
                    if (word_end && settle_last) begin
                        state <= sdc_pkg::SDC_FLT_RUN;
                    end
                end
                sdc_pkg::SDC_FLT_RUN: begin
                    state <= sdc_pkg::SDC_FLT_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt <= '0;
        end else if (sync_rise || fsi_take || state == sdc_pkg::SDC_FLT_RESET) begin
            cnt <= '0;
        end else if (word_end) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + sdc_pkg::CNT_W'(1);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            settle_cnt <= '0;
        end else if (state != sdc_pkg::SDC_FLT_SETTLE || fsi_take) begin
            settle_cnt <= '0;
        end else if (word_end) begin
            settle_cnt <= settle_cnt + 8'h01;
        end
    end

    // Later frame sync pulses leave the sequencer alone
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fsi_locked <= 1'b0;
        end else if (fsi_take) begin
            fsi_locked <= 1'b1;
        end else if (sync_rise) begin
            fsi_locked <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            filter_reset_out <= 1'b0;
            seq_count_out <= '0;
        end else begin
            filter_reset_out <= (state == sdc_pkg::SDC_FLT_RESET) || sync_rise;
            seq_count_out <= cnt[sdc_pkg::CNT_W-1:1];
        end
    end

    // ************************************************************
    // Output register and data ready
    // ************************************************************
    logic [sdc_pkg::WORD_W-1:0] out_word;
    logic [sdc_pkg::WORD_W-1:0] tx_word;
    logic load_ok;
    logic next_data_ready_n_n;

    assign load_ok = word_end && (state == sdc_pkg::SDC_FLT_RUN || settle_last);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            out_word <= '0;
        end else if (load_ok) begin
            out_word <= result_in;
        end
    end

    // High while unsettled, and for the last two master periods of a word
    assign next_data_ready_n_n = (state != sdc_pkg::SDC_FLT_RUN) ||
                         (cnt >= cnt_last - sdc_pkg::DATA_READY_N_CLK);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            data_ready_n_out <= 1'b1;
        end else if (sync_rise || fsi_take) begin
            data_ready_n_out <= 1'b1;
        end else if (load_ok) begin
            data_ready_n_out <= 1'b0;
        end else begin
            data_ready_n_out <= next_data_ready_n_n;
        end
    end

    // ************************************************************
    // Parallel port
    // ************************************************************
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            parallel_data_out <= '0;
            parallel_data_oe_n_out <= 1'b1;
        end else begin
            parallel_data_out <= out_word;
            parallel_data_oe_n_out <= !(act_par && !cs_n_s && !rd_n_s);
        end
    end

    // ************************************************************
    // Serial master port
    // ************************************************************
    logic half_rate;
    logic [4:0] bit_idx;
    logic first_half;
    logic next_sco;
    logic next_sdo;
    logic next_fso;

    // Mode 2 runs the serial clock at half the master rate
    assign half_rate = (act_mode == sdc_pkg::MODE_2);
    assign bit_idx = half_rate ? {1'b0, cnt[5:2]} : cnt[5:1];
    assign first_half = half_rate ? !cnt[1] : !cnt[0];

    // Output word reloads at each frame start and on the first frame sync in
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_word <= '0;
        end else if (fsi_take) begin
            tx_word <= out_word;
        end else if (word_end) begin
            tx_word <= result_in;
        end
    end

    // Data changes where the serial clock edge select says
    assign next_sco = first_half ^ ces_s;

    always_comb begin
        if (bit_idx < 5'(sdc_pkg::WORD_W)) begin
            next_sdo = tx_word[4'(sdc_pkg::WORD_W - 1) - bit_idx[3:0]];
        end else begin
            next_sdo = 1'b0;
        end
    end

    always_comb begin
        if (state == sdc_pkg::SDC_FLT_RESET || fsi_s) begin
            next_fso = 1'b0;
        end else if (act_mode == sdc_pkg::MODE_1 && frame_format_select_s) begin
            next_fso = (bit_idx >= 5'(sdc_pkg::FRAME_LONG / 2));
        end else begin
            next_fso = (bit_idx == 5'h00);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            serial_clock_out <= 1'b0;
            serial_data_out <= 1'b0;
            frame_sync_out <= 1'b0;
            serial_data_oe_n_out <= 1'b1;
        end else begin
            serial_clock_out <= next_sco;
            serial_data_out <= next_sdo;
            frame_sync_out <= next_fso;
            serial_data_oe_n_out <= !(!act_par && (oe_s == slot_s));
        end
    end

    // ************************************************************
    // APB read path
    // ************************************************************
    logic [sdc_pkg::DATA_W-1:0] status_word;

    always_comb begin
        status_word = '0;
        status_word[sdc_pkg::STAT_RUN_BIT] = (state == sdc_pkg::SDC_FLT_RUN);
        status_word[sdc_pkg::STAT_SETTLE_BIT] = (state == sdc_pkg::SDC_FLT_SETTLE);
        status_word[sdc_pkg::STAT_LOCK_BIT] = fsi_locked;
        status_word[sdc_pkg::STAT_PAR_BIT] = act_par;
        status_word[sdc_pkg::STAT_MODE_LSB +: sdc_pkg::MODE_W] = act_mode;
        status_word[sdc_pkg::STAT_SEQ_LSB +: sdc_pkg::SEQ_W] = cnt[sdc_pkg::CNT_W-1:1];
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prdata_out <= '0;
        end else if (apb_setup) begin
            unique case (paddr_in)
                sdc_pkg::REG_CTRL: prdata_out <= ctrl;
                sdc_pkg::REG_STATUS: prdata_out <= status_word;
                sdc_pkg::REG_RESULT: prdata_out <= {16'h0000, out_word};
                default: prdata_out <= '0;
            endcase
        end
    end

    assign pready_out = 1'b1;
    assign pslverr_out = apb_access && !addr_ok;

endmodule

// [bench/sdc_port_sva.sv]
// Checker of the converter port pins, bound to every sdc_port.
// Assumes pins pass two flip-flops inside the block before use.
`timescale 1ns/10ps
module sdc_port_sva #(
    parameter int SETTLE_WORDS = 8
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [sdc_pkg::WORD_W-1:0] result_in,
    input wire logic filter_reset_out,
    input wire logic filter_sync_in,
    input wire logic frame_sync_in,
    input wire logic slot_select_in,
    input wire logic output_enable_in,
    input wire logic chip_select_n_in,
    input wire logic data_ready_n_out,
    input wire logic [sdc_pkg::WORD_W-1:0] parallel_data_out,
    input wire logic parallel_data_oe_n_out,
    input wire logic serial_data_oe_n_out,
    input wire logic frame_sync_out
);
    // ************************************************************
    // Pin relations
    // ************************************************************
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    sync_hold_a: assert property (filter_sync_in [*2] |-> ##2 filter_reset_out)
        else $error("filter not held in reset");
    sync_leave_a: assert property (!filter_sync_in [*7] |-> !filter_reset_out)
        else $error("filter stuck in reset");
    settle_high_a: assert property (filter_reset_out |-> data_ready_n_out)
        else $error("data ready low during reset");
    ready_lead_a: assert property ($fell(data_ready_n_out) |->
        $past(data_ready_n_out, 2) && $past(data_ready_n_out, 4))
        else $error("data ready high too short");
    ready_width_a: assert property ($fell(data_ready_n_out) |->
        (!data_ready_n_out || filter_reset_out) [*8])
        else $error("data ready low too short");
    word_load_a: assert property ($fell(data_ready_n_out) |=>
        parallel_data_out == $past(result_in, 2))
        else $error("output word not loaded");
    bus_float_a: assert property (chip_select_n_in [*5] |=> parallel_data_oe_n_out)
        else $error("parallel bus driven unselected");
    sdo_float_a: assert property ((output_enable_in != slot_select_in) [*5] |=>
        serial_data_oe_n_out)
        else $error("serial data driven out of slot");
    fso_gate_a: assert property (frame_sync_in [*5] |-> !frame_sync_out)
        else $error("frame sync out not gated");
    cover property ($fell(data_ready_n_out));
    cover property ($rose(frame_sync_out));
    cover property ($fell(filter_reset_out));
endmodule

bind sdc_port sdc_port_sva #(.SETTLE_WORDS(SETTLE_WORDS)) sdc_port_sva_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .result_in(result_in),
    .filter_reset_out(filter_reset_out), .filter_sync_in(filter_sync_in),
    .frame_sync_in(frame_sync_in), .slot_select_in(slot_select_in),
    .output_enable_in(output_enable_in), .chip_select_n_in(chip_select_n_in),
    .data_ready_n_out(data_ready_n_out), .parallel_data_out(parallel_data_out),
    .parallel_data_oe_n_out(parallel_data_oe_n_out),
    .serial_data_oe_n_out(serial_data_oe_n_out), .frame_sync_out(frame_sync_out)
);

// [bench/sdc_dsp_model.sv]
// Serial receiver standing in for a processor port in slave mode.
// Assumes clock, data and frame sync are levels sampled by clk_in.
`timescale 1ns/10ps
module sdc_dsp_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic edge_sel_in,
    input wire logic sclk_in,
    input wire logic sdata_in,
    input wire logic fsync_in,
    output logic [15:0] word_out,
    output logic pad_out,
    output logic [7:0] gap_out,
    output logic got_out
);
    logic sclk_q;
    logic fs_q;
    logic pad;
    logic [14:0] sh;
    logic [5:0] n;
    logic [7:0] cyc;
    logic valid;
    // Sample on the edge opposite to the change
    assign valid = edge_sel_in ? (sclk_in && !sclk_q) : (!sclk_in && sclk_q);
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            {sclk_q, fs_q, pad, sh, n, cyc} <= '0;
            {word_out, pad_out, gap_out, got_out} <= '0;
        end else begin
            sclk_q <= sclk_in;
            fs_q <= fsync_in;
            cyc <= (fsync_in && !fs_q) ? 8'h01 : cyc + 8'h01;
            if (fsync_in && !fs_q) begin
                gap_out <= cyc;
            end
            if (valid && fsync_in) begin
                sh <= {14'h0, sdata_in};
                n <= 6'h01;
                pad <= 1'b0;
            end else if (valid && n != 6'h00) begin
                n <= (n == 6'h1f) ? 6'h00 : n + 6'h01;
                if (n < 6'h10) begin
                    sh <= {sh[13:0], sdata_in};
                end else begin
                    pad <= pad | sdata_in;
                end
                if (n == 6'h0f) begin
                    word_out <= {sh, sdata_in};
                end
                if (n == 6'h1f) begin
                    pad_out <= pad | sdata_in;
                end
            end
            got_out <= valid && !fsync_in && n == 6'h0f;
        end
    end
endmodule

// [bench/sdc_port_bench.sv]
// Bench of sdc_port: APB master, pin drive and a serial receiver.
// Assumes sdc_pkg, the bound checker and sdc_dsp_model are compiled first.
`timescale 1ns/10ps
module sdc_port_bench;
    localparam int LONG = sdc_pkg::DECIM_LONG * sdc_pkg::CLK_PER_MCLK;
    logic clk_in = 1'b0, rst_n_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0, prdata_out, rd, n;
    logic [15:0] result_in = 16'h0, parallel_data_out, word;
    logic filter_sync_in = 1'b0, frame_sync_in = 1'b0, clock_edge_select_in = 1'b0;
    logic frame_format_select_in = 1'b0, slot_select_in = 1'b0, output_enable_in = 1'b0;
    logic chip_select_n_in = 1'b1, read_n_in = 1'b1, pready_out, pslverr_out, err, pad, got;
    logic filter_reset_out, data_ready_n_out, parallel_data_oe_n_out, serial_clock_out;
    logic serial_data_out, serial_data_oe_n_out, frame_sync_out;
    logic [4:0] seq_count_out;
    logic [7:0] gap;
    int fail_count = 0, checked = 0, cyc = 0;
    // Serial data line has a pull-up
    wire sdo_line = serial_data_oe_n_out ? 1'b1 : serial_data_out;

    sdc_port #(.SETTLE_WORDS(1)) sdc_port_i (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .result_in(result_in), .filter_reset_out(filter_reset_out),
        .seq_count_out(seq_count_out), .filter_sync_in(filter_sync_in),
        .frame_sync_in(frame_sync_in), .clock_edge_select_in(clock_edge_select_in),
        .frame_format_select_in(frame_format_select_in), .slot_select_in(slot_select_in),
        .output_enable_in(output_enable_in), .chip_select_n_in(chip_select_n_in),
        .read_n_in(read_n_in), .data_ready_n_out(data_ready_n_out),
        .parallel_data_out(parallel_data_out), .parallel_data_oe_n_out(parallel_data_oe_n_out),
        .serial_clock_out(serial_clock_out), .serial_data_out(serial_data_out),
        .serial_data_oe_n_out(serial_data_oe_n_out), .frame_sync_out(frame_sync_out)
    );
    sdc_dsp_model sdc_dsp_model_i (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .edge_sel_in(clock_edge_select_in),
        .sclk_in(serial_clock_out), .sdata_in(sdo_line), .fsync_in(frame_sync_out),
        .word_out(word), .pad_out(pad), .gap_out(gap), .got_out(got)
    );

    // ************************************************************
    // Helpers
    // ************************************************************
    always #50 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (fail_count == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
        checked++;
        if (got_v !== exp_v) begin
            fail_count++;
            $display("BAD %0t value %h expected %h", $time, got_v, exp_v);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk_in);
    endtask
    task automatic settle(input int k);
        tick(k);
        @(negedge clk_in);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do @(posedge clk_in); while (pready_out !== 1'b1);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic fsync();
        filter_sync_in <= 1'b1;
        tick(2);
        filter_sync_in <= 1'b0;
    endtask
    task automatic frames(input int k);
        repeat (k) @(posedge got);
        @(negedge clk_in);
    endtask
    task automatic fsi_pulse();
        @(posedge frame_sync_out);
        tick(8);
        frame_sync_in <= 1'b1;
        tick(2);
        frame_sync_in <= 1'b0;
    endtask
    task automatic fso_count(input int k);
        n = 0;
        repeat (k) begin
            @(negedge clk_in);
            n += frame_sync_out;
        end
    endtask

    // ************************************************************
    // Sequence
    // ************************************************************
    initial begin
        tick(6);
        rst_n_in <= 1'b1;
        apb(1'b0, sdc_pkg::REG_CTRL, 32'h0);
        chk(rd, sdc_pkg::CTRL_RESET);
        apb(1'b0, 8'h40, 32'h0);
        chk({err, rd[30:0]}, 32'h8000_0000);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, sdc_pkg::REG_CTRL, 32'(i + 1));
            clock_edge_select_in <= i[0];
            frame_format_select_in <= 1'(i != 0);
            result_in <= 16'h9a5c ^ 16'(i * 16'h1111);
            fsync();
            settle(8);
            chk({31'h0, data_ready_n_out}, 32'h1);
            frames(3);
            chk({16'h0, word}, {16'h0, result_in});
            chk({24'h0, gap}, (i == 2) ? LONG / 2 : LONG);
            if (i == 0) chk({31'h0, pad}, 32'h0);
            apb(1'b0, sdc_pkg::REG_RESULT, 32'h0);
            chk(rd, {16'h0, result_in});
        end
        apb(1'b1, sdc_pkg::REG_CTRL, 32'h1);
        clock_edge_select_in <= 1'b0;
        frame_format_select_in <= 1'b0;
        fsync();
        frames(2);
        fsi_pulse();
        frames(1);
        chk({24'h0, gap}, LONG);
        fso_count(LONG);
        chk(n, 32'(sdc_pkg::CLK_PER_MCLK));
        apb(1'b1, sdc_pkg::REG_CTRL, 32'h2);
        frame_format_select_in <= 1'b1;
        fsync();
        frames(2);
        fsi_pulse();
        n = 0;
        while (frame_sync_out !== 1'b1 && n < 40) begin
            @(negedge clk_in);
            n++;
        end
        chk(32'(n > 0 && n < 8), 32'h1);
        frames(1);
        repeat (2) fsi_pulse();
        frames(1);
        chk({24'h0, gap}, LONG);
        chk({16'h0, word}, {16'h0, result_in});
        @(posedge clk_in);
        frame_sync_in <= 1'b1;
        tick(4);
        fso_count(140);
        chk(n, 32'h0);
        settle(2);
        chk({31'h0, serial_data_oe_n_out}, 32'h0);
        @(posedge clk_in);
        frame_sync_in <= 1'b0;
        output_enable_in <= 1'b1;
        settle(5);
        chk({30'h0, serial_data_oe_n_out, sdo_line}, 32'h3);
        @(posedge clk_in);
        slot_select_in <= 1'b1;
        settle(5);
        chk({31'h0, serial_data_oe_n_out}, 32'h0);
        apb(1'b1, sdc_pkg::REG_CTRL, 32'h5);
        chip_select_n_in <= 1'b0;
        read_n_in <= 1'b0;
        result_in <= 16'hc3a5;
        fsync();
        repeat (2) @(negedge data_ready_n_out);
        settle(3);
        chk({16'h0, parallel_data_out}, 32'h0000_c3a5);
        chk({31'h0, parallel_data_oe_n_out}, 32'h0);
        fso_count(LONG);
        chk(n, LONG / 2);
        @(posedge clk_in);
        chip_select_n_in <= 1'b1;
        settle(5);
        chk({31'h0, parallel_data_oe_n_out}, 32'h1);
        end_of_test();
    end
endmodule
